// [rccs_asserts.sv]
// Concurrent checks on the RC trim and clock switch block ports
`timescale 1ns/1ps
`include "rccs_defs.vh"
module rccs_asserts (
  input wire       clk_i,
  input wire       rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       icp_wr_i,
  input wire [7:0] icp_addr_i,
  input wire       icp_mode_i,
  input wire [1:0] startup_clock_select_i,
  input wire       wakeup_halt_i,
  input wire [9:0] rc_trim_o,
  input wire       rc_osc_en_o,
  input wire       wu_osc_en_o,
  input wire       xtal_osc_en_o,
  input wire       icp_refused_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Properties
  a_trim_reset: assert property ($fell(rst_i) |-> rc_trim_o == 10'h3FF)
    else $error("trim not at default after reset");
  a_trim_high: assert property (wr_i && addr_i == `RCCS_ADDR_TRIM_HIGH
    |=> rc_trim_o[9:2] == $past(wdata_i)) else $error("trim high not taken");
  a_trim_low: assert property (wr_i && addr_i == `RCCS_ADDR_TRIM_LOW
    |=> rc_trim_o[1:0] == $past(wdata_i[6:5])) else $error("trim low not taken");
  a_icp_refuse: assert property (icp_wr_i && (icp_addr_i == `RCCS_ADDR_FACT_HIGH
    || icp_addr_i == `RCCS_ADDR_FACT_LOW) |-> icp_refused_o) else $error("factory write let in");
  a_icp_rc_forced: assert property (icp_mode_i |-> rc_osc_en_o)
    else $error("programming mode without internal RC");
  a_wu_ext_on: assert property (startup_clock_select_i == `RCCS_STARTUP_CLOCK_SELECT_EXT |-> wu_osc_en_o)
    else $error("wakeup RC off with external clock");
  a_wu_halt_on: assert property (wakeup_halt_i |-> wu_osc_en_o)
    else $error("wakeup RC off in wakeup halt");
  a_xtal_running: assert property (xtal_osc_en_o)
    else $error("crystal oscillator stopped");
endmodule

// [rccs_defs.vh]
// Constants for the RC trim and clock switch block
`ifndef RCCS_DEFS_VH
`define RCCS_DEFS_VH
`define RCCS_ADDR_TRIM_HIGH   8'h00
`define RCCS_ADDR_TRIM_LOW    8'h01
`define RCCS_ADDR_TRIM_CTRL   8'h02
`define RCCS_ADDR_SWITCH      8'h03
`define RCCS_ADDR_FACT_HIGH   8'h04
`define RCCS_ADDR_FACT_LOW    8'h05
`define RCCS_ADDR_USER_HIGH   8'h06
`define RCCS_ADDR_USER_LOW    8'h07
`define RCCS_ADDR_OPTIONS     8'h08
`define RCCS_TRIM_RESET       8'hFF
`define RCCS_CTRL_PGM_BIT     0
`define RCCS_CTRL_LAT_BIT     1
`define RCCS_SW_SEL_BIT       0
`define RCCS_SW_RCRDY_BIT     1
`define RCCS_SW_WURDY_BIT     2
`define RCCS_LOW_TRIM_MSB     6
`define RCCS_LOW_TRIM_LSB     5
`define RCCS_WU_WAIT_CYC      3
`define RCCS_RC_WAIT_CYC      8
`define RCCS_INTERNAL_OSC_READY_FLAG_CYC      2
`define RCCS_PGM_CYC          16'h0100
`define RCCS_STARTUP_CLOCK_SELECT_WAKEUP     2'h3
`define RCCS_STARTUP_CLOCK_SELECT_EXT        2'h2
`endif

// [rccs_top.v]
// RC oscillator trim registers, user trim store and RC clock switch
`timescale 1ns/1ps
`include "rccs_defs.vh"

// How it works
// - Trim is ten bits: high register plus low register bits 6:5.
// - Any reset returns trim registers to FFh; software reloads them.
// - Factory trim bytes readable, bits 1:0 at positions 6:5, read-only.
// - Programming-port erase or program of factory area is refused.
// - In-circuit programming mode forces internal RC as clock source.
// - While latch bit set, writes to user trim bytes are latched.
// - Setting program bit starts cycle writing latches into user cells.
// - End of programming clears program and latch bits together.
// - Read of user bytes with latch bit set leaves bus undriven.
// - Write to user bytes with latch bit clear is ignored.
// - Reset during programming leaves user cells holding their old contents.
// - Read-out protection blocks user bytes; removal erases both.
// - Two-bit startup select option can choose the wakeup RC.
// - To wakeup RC: drop Internal_osc_ready_flag, hold clock high, wait 3, switch.
// - Back to RC: count 8 on 4-bit counter, drop wakeup flag, count 2 more, raise RC flag, switch.
// - Internal RC stopped while wakeup RC is selected, except in programming mode and during the switch back.
// - RC selected: wakeup RC on when entering auto-wakeup halt.
// - External clock selected: wakeup RC always running.
// - Crystal oscillator kept running during reset.
// - Latch bit cleared by software only with program bit clear; 7:2 zero.
module rccs_top #(
  parameter PGM_CYC = `RCCS_PGM_CYC
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  output reg        rdata_en_o,
  input  wire       icp_mode_i,
  input  wire       icp_wr_i,
  input  wire [7:0] icp_addr_i,
  input  wire [1:0] startup_clock_select_i,
  input  wire       readout_prot_i,
  input  wire       wakeup_halt_i,
  input  wire       rc_clk_i,
  input  wire       wu_clk_i,
  input  wire [7:0] fact_high_i,
  input  wire [1:0] fact_low_i,
  output wire [9:0] rc_trim_o,
  output reg        sys_clk_o,
  output wire       rc_osc_en_o,
  output wire       wu_osc_en_o,
  output wire       xtal_osc_en_o,
  output wire       icp_refused_o
);

  // ==========================================================
  // Trim registers
  reg [7:0] trim_high_q;
  reg [1:0] trim_low_q;
  reg       lat_q;
  reg       pgm_q;
  reg [15:0] pgm_cnt_q;
  reg [7:0] latch_high_q;
  reg [1:0] latch_low_q;
  reg [7:0] user_high_q;
  reg [1:0] user_low_q;
  reg       prot_q;
  reg       sel_q;

  // ==========================================================
  // Bus decodes
  wire wr_user         = wr_i && (addr_i == `RCCS_ADDR_USER_HIGH ||
                                  addr_i == `RCCS_ADDR_USER_LOW);
  wire ctrl_wr         = wr_i && (addr_i == `RCCS_ADDR_TRIM_CTRL);
  wire lat_wr          = wdata_i[`RCCS_CTRL_LAT_BIT];
  wire pgm_wr          = wdata_i[`RCCS_CTRL_PGM_BIT];
  // Last count of a programming cycle; counter starts at zero
  wire pgm_done        = pgm_q && (pgm_cnt_q == PGM_CYC[15:0] - 16'h0001);
  wire user_rd_blocked = lat_q || prot_q;
  wire user_take       = wr_user && lat_q && !pgm_q && !prot_q;

  assign rc_trim_o = {trim_high_q, trim_low_q};

  always @(posedge clk_i) begin
    if (rst_i) begin
      trim_high_q <= `RCCS_TRIM_RESET;
      trim_low_q  <= 2'h3;
      sel_q       <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == `RCCS_ADDR_TRIM_HIGH) begin
        trim_high_q <= wdata_i;
      end
      if (addr_i == `RCCS_ADDR_TRIM_LOW) begin
        trim_low_q <= wdata_i[`RCCS_LOW_TRIM_MSB:`RCCS_LOW_TRIM_LSB];
      end
      if (addr_i == `RCCS_ADDR_SWITCH) begin
        sel_q <= wdata_i[`RCCS_SW_SEL_BIT];
      end
    end
  end

  // ==========================================================
  // User trim store
  always @(posedge clk_i) begin
    if (rst_i) begin
      lat_q     <= 1'b0;
      pgm_q     <= 1'b0;
      pgm_cnt_q <= 16'h0000;
    end else if (pgm_done) begin
      lat_q     <= 1'b0;
      pgm_q     <= 1'b0;
      pgm_cnt_q <= 16'h0000;
    end else begin
      if (pgm_q) begin
        pgm_cnt_q <= pgm_cnt_q + 16'h0001;
      end
      if (ctrl_wr) begin
        // latch bit cleared only while idle
        if (lat_wr) begin
          lat_q <= 1'b1;
        end else if (!pgm_q) begin
          lat_q <= 1'b0;
        end
        // program start needs latch bit; protection blocks rewrites
        if (pgm_wr && (lat_q || lat_wr) && !prot_q) begin
          pgm_q <= 1'b1;
        end
      end
    end
  end

  // Cells are only set by the final cycle or by protection removal; a reset mid-cycle leaves them as they were
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch_high_q <= 8'h00;
      latch_low_q  <= 2'h0;
      prot_q       <= 1'b0;
    end else begin
      prot_q <= readout_prot_i;
      // capture while latch bit set; ignored when clear
      if (user_take) begin
        if (addr_i == `RCCS_ADDR_USER_HIGH) begin
          latch_high_q <= wdata_i;
        end else begin
          latch_low_q <= wdata_i[`RCCS_LOW_TRIM_MSB:`RCCS_LOW_TRIM_LSB];
        end
      end
    end
  end

  // cells have no reset; an interrupted cycle leaves their contents unchanged
  // No reset branch: the cells stand for storage that outlives a reset
  always @(posedge clk_i) begin
    if (prot_q && !readout_prot_i) begin
      user_high_q <= 8'hFF;
      user_low_q  <= 2'h3;
    end else if (pgm_done) begin
      user_high_q <= latch_high_q;
      user_low_q  <= latch_low_q;
    end
  end

  // refuse programming-port access to factory bytes
  assign icp_refused_o = icp_wr_i &&
    (icp_addr_i == `RCCS_ADDR_FACT_HIGH || icp_addr_i == `RCCS_ADDR_FACT_LOW);

  // ==========================================================
  // Clock switch, sampled in the system domain
  // Oscillator inputs are sampled levels; each phase must span
  // several clk_i cycles or edges are lost
  localparam ST_RC     = 3'h0;
  localparam ST_TO_WU  = 3'h1;
  localparam ST_WU     = 3'h2;
  localparam ST_TO_RC  = 3'h3;
  localparam ST_RC_FLG = 3'h4;

  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg       rc_rdy_q;
  reg       wu_rdy_q;
  reg       use_wu_q;
  reg       rc_p_q;
  reg       wu_p_q;
  wire      rc_rise = rc_clk_i && !rc_p_q;
  wire      wu_rise = wu_clk_i && !wu_p_q;
  wire      opt_wu  = startup_clock_select_i == `RCCS_STARTUP_CLOCK_SELECT_WAKEUP;
  wire      want_wu = !icp_mode_i && (sel_q || opt_wu);

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= ST_RC;
      cnt_q    <= 4'h0;
      rc_rdy_q <= 1'b1;
      wu_rdy_q <= 1'b0;
      use_wu_q <= 1'b0;
      // Idle level from the pins, so no false edge after reset
      rc_p_q   <= rc_clk_i;
      wu_p_q   <= wu_clk_i;
    end else begin
      rc_p_q <= rc_clk_i;
      wu_p_q <= wu_clk_i;
      case (st_q)
        ST_RC: begin
          if (want_wu) begin
            rc_rdy_q <= 1'b0;
            cnt_q    <= 4'h0;
            st_q     <= ST_TO_WU;
          end
        end
        ST_TO_WU: begin
          if (wu_rise) begin
            if (cnt_q == `RCCS_WU_WAIT_CYC - 1) begin
              wu_rdy_q <= 1'b1;
              use_wu_q <= 1'b1;
              st_q     <= ST_WU;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_WU: begin
          if (!want_wu) begin
            cnt_q <= 4'h0;
            st_q  <= ST_TO_RC;
          end
        end
        ST_TO_RC: begin
          // eight RC cycles on a 4-bit count
          if (rc_rise) begin
            if (cnt_q == `RCCS_RC_WAIT_CYC - 1) begin
              wu_rdy_q <= 1'b0;
              cnt_q    <= 4'h0;
              st_q     <= ST_RC_FLG;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_RC_FLG: begin
          if (rc_rise) begin
            if (cnt_q == `RCCS_INTERNAL_OSC_READY_FLAG_CYC - 1) begin
              rc_rdy_q <= 1'b1;
              use_wu_q <= 1'b0;
              st_q     <= ST_RC;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        default: st_q <= ST_RC;
      endcase
    end
  end

  // ==========================================================
  // Clock mux
  // Both sources held off while changing
  wire      in_transit = st_q == ST_TO_WU || st_q == ST_TO_RC || st_q == ST_RC_FLG;

  // Switch only on a rising edge; hold high in between, so no runt low
  // Trade-off: one high phase is stretched for the length of the change
  always @(posedge clk_i) begin
    if (rst_i)
      sys_clk_o <= 1'b1;
    else if (in_transit)
      sys_clk_o <= 1'b1;
    else if (use_wu_q)
      sys_clk_o <= wu_clk_i;
    else
      sys_clk_o <= rc_clk_i;
  end

  // ==========================================================
  // Oscillator enables
  // RC stopped when not selected, except while switching back to it
  // programming mode runs the RC at once, not after the switch
  assign rc_osc_en_o = icp_mode_i || !use_wu_q ||
                       st_q == ST_TO_RC || st_q == ST_RC_FLG;
  assign wu_osc_en_o = use_wu_q || st_q == ST_TO_WU || wakeup_halt_i ||
                       startup_clock_select_i == `RCCS_STARTUP_CLOCK_SELECT_EXT;
  // crystal never stopped, reset included
  // No reset term: the resonator must not restart after a reset
  assign xtal_osc_en_o = 1'b1;

  // ==========================================================
  // Read port
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o    <= 8'h00;
      rdata_en_o <= 1'b0;
    end else begin
      rdata_o    <= 8'h00;
      rdata_en_o <= rd_i;
      // Unmapped addresses and reserved bits read zero
      if (rd_i) begin
        case (addr_i)
          `RCCS_ADDR_TRIM_HIGH: rdata_o <= trim_high_q;
          `RCCS_ADDR_TRIM_LOW:  rdata_o <= {1'b0, trim_low_q, 5'h00};
          `RCCS_ADDR_TRIM_CTRL: rdata_o <= {6'h00, lat_q, pgm_q};
          `RCCS_ADDR_SWITCH:    rdata_o <= {5'h00, wu_rdy_q, rc_rdy_q, sel_q};
          `RCCS_ADDR_FACT_HIGH: rdata_o <= fact_high_i;
          `RCCS_ADDR_FACT_LOW:  rdata_o <= {1'b0, fact_low_i, 5'h00};
          `RCCS_ADDR_USER_HIGH: begin
            if (user_rd_blocked) begin
              rdata_en_o <= 1'b0;
            end else begin
              rdata_o <= user_high_q;
            end
          end
          `RCCS_ADDR_USER_LOW: begin
            if (user_rd_blocked) begin
              rdata_en_o <= 1'b0;
            end else begin
              rdata_o <= {1'b0, user_low_q, 5'h00};
            end
          end
          `RCCS_ADDR_OPTIONS: rdata_o <= {5'h00, readout_prot_i, startup_clock_select_i};
          default:            rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

// [test_rc_calibration_and_clock_switch.sv]
// Self-checking bench for the RC trim and clock switch block
`timescale 1ns/1ps
`include "rccs_defs.vh"
module test_rc_calibration_and_clock_switch;
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg  [7:0] addr_i = 8'h00, wdata_i = 8'h00, icp_addr_i = 8'h00, fact_high_i = 8'h5A;
  reg        wr_i = 1'b0, rd_i = 1'b0, icp_mode_i = 1'b0, icp_wr_i = 1'b0;
  reg        readout_prot_i = 1'b0, wakeup_halt_i = 1'b0, rc_clk_i = 1'b0, wu_clk_i = 1'b0;
  reg  [1:0] startup_clock_select_i = 2'h0, fact_low_i = 2'h1;
  wire [7:0] rdata_o;
  wire [9:0] rc_trim_o;
  wire       rdata_en_o, sys_clk_o, rc_osc_en_o, wu_osc_en_o, xtal_osc_en_o, icp_refused_o;
  integer    miscompares = 0, checked = 0, n = 0;
  rccs_top #(.PGM_CYC(4)) uut (.*);
  initial forever #10 clk_i = ~clk_i;
  // ==========================================
  // Slow oscillators, each runs only while enabled
  always @(posedge clk_i) begin
    n <= n + 1;
    if (n % 4 == 3 && rc_osc_en_o === 1'b1) rc_clk_i <= ~rc_clk_i;
    if (n % 10 == 9 && wu_osc_en_o === 1'b1) wu_clk_i <= ~wu_clk_i;
  end
  // ==========================================
  // Bus and compare tasks
  task chk(input [9:0] got, input [9:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // Data only judged when the bus is expected driven
  task rd(input [7:0] a, input [8:0] exp);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk({1'b0, rdata_en_o, rdata_o & {8{exp[8]}}}, {1'b0, exp});
    end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    begin
      chk(rc_trim_o, 10'h3FF);
      rd(`RCCS_ADDR_TRIM_HIGH, 9'h1FF);
      wr(`RCCS_ADDR_TRIM_CTRL, 8'hFD);
      rd(`RCCS_ADDR_TRIM_CTRL, 9'h100);
      $display("test reset done");
    end
  endtask
  task t_trim;
    begin
      wr(`RCCS_ADDR_TRIM_HIGH, 8'hA5);
      wr(`RCCS_ADDR_TRIM_LOW, 8'h40);
      #1 chk(rc_trim_o, 10'h296);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 chk(rc_trim_o, 10'h3FF);
      $display("test trim done");
    end
  endtask
  task t_fact;
    begin
      rd(`RCCS_ADDR_FACT_HIGH, 9'h15A);
      rd(`RCCS_ADDR_FACT_LOW, 9'h120);
      wr(`RCCS_ADDR_FACT_HIGH, 8'h00);
      rd(`RCCS_ADDR_FACT_HIGH, 9'h15A);
      @(posedge clk_i);
      icp_mode_i <= 1'b1;
      icp_wr_i <= 1'b1;
      icp_addr_i <= `RCCS_ADDR_FACT_LOW;
      #1 chk(icp_refused_o, 10'h1);
      chk(rc_osc_en_o, 10'h1);
      @(posedge clk_i);
      icp_addr_i <= `RCCS_ADDR_USER_HIGH;
      #1 chk(icp_refused_o, 10'h0);
      @(posedge clk_i);
      icp_wr_i <= 1'b0;
      icp_mode_i <= 1'b0;
      $display("test factory done");
    end
  endtask
  task t_user;
    begin
      wr(`RCCS_ADDR_TRIM_CTRL, 8'h02);
      rd(`RCCS_ADDR_USER_HIGH, 9'h000);
      wr(`RCCS_ADDR_USER_HIGH, 8'hAB);
      wr(`RCCS_ADDR_USER_LOW, 8'h40);
      wr(`RCCS_ADDR_TRIM_CTRL, 8'h03);
      repeat (10) @(posedge clk_i);
      rd(`RCCS_ADDR_TRIM_CTRL, 9'h100);
      rd(`RCCS_ADDR_USER_HIGH, 9'h1AB);
      rd(`RCCS_ADDR_USER_LOW, 9'h140);
      wr(`RCCS_ADDR_USER_HIGH, 8'h11);
      rd(`RCCS_ADDR_USER_HIGH, 9'h1AB);
      readout_prot_i <= 1'b1;
      rd(`RCCS_ADDR_USER_HIGH, 9'h000);
      readout_prot_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(`RCCS_ADDR_USER_HIGH, 9'h1FF);
      $display("test user bytes done");
    end
  endtask
  task t_switch;
    begin
      @(posedge clk_i);
      startup_clock_select_i <= `RCCS_STARTUP_CLOCK_SELECT_EXT;
      #1 chk(wu_osc_en_o, 10'h1);
      startup_clock_select_i <= 2'h0;
      wakeup_halt_i <= 1'b1;
      #1 chk(wu_osc_en_o, 10'h1);
      wakeup_halt_i <= 1'b0;
      wr(`RCCS_ADDR_SWITCH, 8'h01);
      rd(`RCCS_ADDR_SWITCH, 9'h101);
      chk(sys_clk_o, 10'h1);
      repeat (100) @(posedge clk_i);
      rd(`RCCS_ADDR_SWITCH, 9'h105);
      chk(rc_osc_en_o, 10'h0);
      wr(`RCCS_ADDR_SWITCH, 8'h00);
      repeat (140) @(posedge clk_i);
      rd(`RCCS_ADDR_SWITCH, 9'h102);
      chk(rc_osc_en_o, 10'h1);
      @(posedge clk_i);
      startup_clock_select_i <= `RCCS_STARTUP_CLOCK_SELECT_WAKEUP;
      repeat (100) @(posedge clk_i);
      rd(`RCCS_ADDR_SWITCH, 9'h104);
      @(posedge clk_i);
      icp_mode_i <= 1'b1;
      #1 chk(rc_osc_en_o, 10'h1);
      repeat (140) @(posedge clk_i);
      rd(`RCCS_ADDR_SWITCH, 9'h102);
      @(posedge clk_i);
      icp_mode_i <= 1'b0;
      startup_clock_select_i <= 2'h0;
      $display("test clock switch done");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_trim;
    t_fact;
    t_user;
    t_switch;
    complete_run;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule
bind rccs_top rccs_asserts u_chk (.*);
